// ---- hdl/cai_core.sv ----
/*
  Sequencer and register file for the add-instruction subset: add B to the
  second index, add-with-carry and plain add into either accumulator.
  Assumes a read-only memory that returns data in the same cycle as the
  address, and a preload port used to set up registers between tests.
*/
`timescale 1ns/1ps
module cai_core (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  bus_data_in,
  input  wire logic        load_strobe,
  input  wire logic [15:0] load_pc,
  input  wire logic [7:0]  load_first_acc,
  input  wire logic [7:0]  load_second_accumulator,
  input  wire logic [15:0] load_first_index_reg,
  input  wire logic [15:0] load_second_index_reg,
  input  wire logic [7:0]  load_ccr,
  output logic      [15:0] bus_addr,
  output logic             bus_rw,
  output logic      [15:0] pc,
  output logic      [7:0]  first_acc,
  output logic      [7:0]  second_accumulator,
  output logic      [15:0] first_index_reg,
  output logic      [15:0] second_index_reg,
  output logic      [7:0]  ccr,
  output logic             instr_done
);

  logic                rst_meta_reg;
  logic                rst_n_sync;
  cai_pkg::cai_state_t st_reg,   st_next;
  cai_pkg::cai_dec_t   dec_reg,  dec_next;
  logic [15:0]         pc_reg,   pc_next;
  logic [15:0]         addr_reg, addr_next;
  logic [7:0]          a_reg,    a_next;
  logic [7:0]          b_reg,    b_next;
  logic [15:0]         x_reg,    x_next;
  logic [15:0]         y_reg,    y_next;
  logic [7:0]          ccr_reg,  ccr_next;
  logic [7:0]          hi_reg,   hi_next;
  logic                page2_reg, page2_next;
  logic                aby_reg,  aby_next;
  logic                done_reg, done_next;
  logic [2:0]          cyc_reg,  cyc_next;
  logic                rw_reg;
  logic                exec_now;
  cai_pkg::cai_dec_t   dec_in;
  localparam logic [2:0] CYC_ONE = 3'h1; // Step of the bus cycle counter.

  cai_alu_if alu_bus ();

  cai_alu u_alu (
    .a (alu_bus)
  );

  // Reset is asserted at once but released through two flops.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  // Maps a first or second opcode byte to accumulator, carry and mode.
  function automatic cai_pkg::cai_dec_t decode_op(input logic [7:0] op);
    cai_pkg::cai_dec_t d;
    d = '{hit: 1'b1, to_b: 1'b0, with_c: 1'b1, mode: cai_pkg::MODE_NONE};
    unique case (op)
      cai_pkg::OP_ADD_CARRY_TO_FIRST_ACC_LIT: d.mode = cai_pkg::MODE_LIT;
      cai_pkg::OP_ADD_CARRY_TO_FIRST_ACC_PZ:  d.mode = cai_pkg::MODE_PAGE0;
      cai_pkg::OP_ADD_CARRY_TO_FIRST_ACC_FUL: d.mode = cai_pkg::MODE_FULL;
      cai_pkg::OP_ADD_CARRY_TO_FIRST_ACC_IDX: d.mode = cai_pkg::MODE_IDX;
      cai_pkg::OP_ADD_CARRY_TO_SECOND_ACC_LIT: d = '{1'b1, 1'b1, 1'b1, cai_pkg::MODE_LIT};
      cai_pkg::OP_ADD_CARRY_TO_SECOND_ACC_PZ:  d = '{1'b1, 1'b1, 1'b1, cai_pkg::MODE_PAGE0};
      cai_pkg::OP_ADD_CARRY_TO_SECOND_ACC_FUL: d = '{1'b1, 1'b1, 1'b1, cai_pkg::MODE_FULL};
      cai_pkg::OP_ADD_CARRY_TO_SECOND_ACC_IDX: d = '{1'b1, 1'b1, 1'b1, cai_pkg::MODE_IDX};
      cai_pkg::OP_PLAIN_ADD_FIRST_ACC_LIT: d = '{1'b1, 1'b0, 1'b0, cai_pkg::MODE_LIT};
      cai_pkg::OP_PLAIN_ADD_FIRST_ACC_PZ:  d = '{1'b1, 1'b0, 1'b0, cai_pkg::MODE_PAGE0};
      cai_pkg::OP_PLAIN_ADD_FIRST_ACC_FUL: d = '{1'b1, 1'b0, 1'b0, cai_pkg::MODE_FULL};
      cai_pkg::OP_PLAIN_ADD_FIRST_ACC_IDX: d = '{1'b1, 1'b0, 1'b0, cai_pkg::MODE_IDX};
      cai_pkg::OP_PLAIN_ADD_SECOND_ACC_LIT: d = '{1'b1, 1'b1, 1'b0, cai_pkg::MODE_LIT};
      cai_pkg::OP_PLAIN_ADD_SECOND_ACC_PZ:  d = '{1'b1, 1'b1, 1'b0, cai_pkg::MODE_PAGE0};
      cai_pkg::OP_PLAIN_ADD_SECOND_ACC_FUL: d = '{1'b1, 1'b1, 1'b0, cai_pkg::MODE_FULL};
      cai_pkg::OP_PLAIN_ADD_SECOND_ACC_IDX: d = '{1'b1, 1'b1, 1'b0, cai_pkg::MODE_IDX};
      default:              d.hit = 1'b0;
    endcase
    return d;
  endfunction

  // Expected bus cycle count of an accumulator add, used by the checks.
  function automatic logic [2:0] cyc_expect(input cai_pkg::cai_mode_t md,
                                            input logic p2);
    logic [2:0] n;
    n = cai_pkg::CYC_LIT;
    unique case (md)
      cai_pkg::MODE_PAGE0: n = cai_pkg::CYC_PZ;
      cai_pkg::MODE_FULL:  n = cai_pkg::CYC_FULL;
      cai_pkg::MODE_IDX:   n = p2 ? cai_pkg::CYC_IDX_Y : cai_pkg::CYC_IDX_X;
      default:             n = cai_pkg::CYC_LIT;
    endcase
    return n;
  endfunction

  // The adder always sees the selected accumulator and the bus byte.
  assign dec_in         = decode_op(bus_data_in);
  assign alu_bus.x      = dec_reg.to_b ? b_reg : a_reg;
  assign alu_bus.m      = bus_data_in;
  assign alu_bus.cin    = ccr_reg[cai_pkg::CC_C];
  assign alu_bus.with_c = dec_reg.with_c;
  assign exec_now = (st_reg == cai_pkg::ST_OPREAD) ||
                    (st_reg == cai_pkg::ST_OPND &&
                     dec_reg.mode == cai_pkg::MODE_LIT);

  // Next-state logic. Each state is one bus read; addr_next is the address
  // of the read that the next state performs. Unknown opcodes cost one
  // cycle and are skipped, since nothing else is decoded here.
  always_comb begin
    st_next    = st_reg;
    dec_next   = dec_reg;
    pc_next    = pc_reg;
    addr_next  = addr_reg;
    a_next     = a_reg;
    b_next     = b_reg;
    x_next     = x_reg;
    y_next     = y_reg;
    ccr_next   = ccr_reg;
    hi_next    = hi_reg;
    page2_next = page2_reg;
    aby_next   = aby_reg;
    done_next  = 1'b0;
    cyc_next   = cyc_reg + CYC_ONE;
    unique case (st_reg)
      cai_pkg::ST_FETCH: begin
        pc_next    = pc_reg + cai_pkg::ADDR_STEP;
        addr_next  = pc_reg + cai_pkg::ADDR_STEP;
        page2_next = 1'b0;
        aby_next   = 1'b0;
        if (bus_data_in == cai_pkg::OP_PREFIX2) begin
          st_next = cai_pkg::ST_PAGE2;
        end else if (dec_in.hit) begin
          dec_next = dec_in;
          st_next  = cai_pkg::ST_OPND;
        end else begin
          cyc_next = cai_pkg::CYC_FIRST;
        end
      end
      cai_pkg::ST_PAGE2: begin
        pc_next   = pc_reg + cai_pkg::ADDR_STEP;
        addr_next = pc_reg + cai_pkg::ADDR_STEP;
        if (bus_data_in == cai_pkg::OP_ADD_B_Y) begin
          aby_next = 1'b1;
          st_next  = cai_pkg::ST_ABY3;
        end else if (dec_in.hit && dec_in.mode == cai_pkg::MODE_IDX) begin
          dec_next   = dec_in;
          page2_next = 1'b1;
          st_next    = cai_pkg::ST_OPND;
        end else begin
          st_next  = cai_pkg::ST_FETCH;
          cyc_next = cai_pkg::CYC_FIRST;
        end
      end
      cai_pkg::ST_ABY3: begin
        // Reads the byte after the opcode without consuming it.
        st_next   = cai_pkg::ST_IDLE;
        addr_next = cai_pkg::IDLE_ADDR;
      end
      cai_pkg::ST_OPND: begin
        pc_next   = pc_reg + cai_pkg::ADDR_STEP;
        addr_next = pc_reg + cai_pkg::ADDR_STEP;
        hi_next   = bus_data_in;
        unique case (dec_reg.mode)
          cai_pkg::MODE_PAGE0: begin
            st_next   = cai_pkg::ST_OPREAD;
            addr_next = {cai_pkg::PAGE_ZERO_HI, bus_data_in};
          end
          cai_pkg::MODE_FULL: st_next = cai_pkg::ST_EXTLO;
          cai_pkg::MODE_IDX: begin
            st_next   = cai_pkg::ST_IDLE;
            addr_next = cai_pkg::IDLE_ADDR;
          end
          default: begin
            st_next  = cai_pkg::ST_FETCH;
            cyc_next = cai_pkg::CYC_FIRST;
          end
        endcase
      end
      cai_pkg::ST_EXTLO: begin
        pc_next   = pc_reg + cai_pkg::ADDR_STEP;
        st_next   = cai_pkg::ST_OPREAD;
        addr_next = {hi_reg, bus_data_in};
      end
      cai_pkg::ST_IDLE: begin
        // Data returned here is ignored.
        if (aby_reg) begin
          y_next    = y_reg + {cai_pkg::ZERO_BYTE, b_reg};
          done_next = 1'b1;
          st_next   = cai_pkg::ST_FETCH;
          addr_next = pc_reg;
          cyc_next  = cai_pkg::CYC_FIRST;
        end else begin
          st_next   = cai_pkg::ST_OPREAD;
          addr_next = (page2_reg ? y_reg : x_reg) +
                      {cai_pkg::ZERO_BYTE, hi_reg};
        end
      end
      cai_pkg::ST_OPREAD: begin
        st_next   = cai_pkg::ST_FETCH;
        addr_next = pc_reg;
        cyc_next  = cai_pkg::CYC_FIRST;
      end
    endcase
    // Accumulator adds retire on the cycle that reads the operand.
    if (exec_now) begin
      if (dec_reg.to_b) b_next = alu_bus.r;
      else a_next = alu_bus.r;
      ccr_next[cai_pkg::CC_H] = alu_bus.h;
      ccr_next[cai_pkg::CC_N] = alu_bus.n;
      ccr_next[cai_pkg::CC_Z] = alu_bus.z;
      ccr_next[cai_pkg::CC_V] = alu_bus.v;
      ccr_next[cai_pkg::CC_C] = alu_bus.c;
      done_next = 1'b1;
    end
    if (load_strobe) begin
      st_next   = cai_pkg::ST_FETCH;
      pc_next   = load_pc;
      addr_next = load_pc;
      a_next    = load_first_acc;
      b_next    = load_second_accumulator;
      x_next    = load_first_index_reg;
      y_next    = load_second_index_reg;
      ccr_next  = load_ccr;
      done_next = 1'b0;
      cyc_next  = cai_pkg::CYC_FIRST;
    end
  end

  // Registers only; the bus direction is a constant read.
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      st_reg    <= cai_pkg::ST_FETCH;
      dec_reg   <= '{1'b0, 1'b0, 1'b0, cai_pkg::MODE_NONE};
      pc_reg    <= cai_pkg::RESET_PC;
      addr_reg  <= cai_pkg::RESET_PC;
      a_reg     <= cai_pkg::RESET_ACC;
      b_reg     <= cai_pkg::RESET_ACC;
      x_reg     <= cai_pkg::RESET_IDX;
      y_reg     <= cai_pkg::RESET_IDX;
      ccr_reg   <= cai_pkg::RESET_CCR;
      hi_reg    <= cai_pkg::ZERO_BYTE;
      page2_reg <= 1'b0;
      aby_reg   <= 1'b0;
      done_reg  <= 1'b0;
      cyc_reg   <= cai_pkg::CYC_FIRST;
      rw_reg    <= 1'b1;
    end else begin
      st_reg    <= st_next;
      dec_reg   <= dec_next;
      pc_reg    <= pc_next;
      addr_reg  <= addr_next;
      a_reg     <= a_next;
      b_reg     <= b_next;
      x_reg     <= x_next;
      y_reg     <= y_next;
      ccr_reg   <= ccr_next;
      hi_reg    <= hi_next;
      page2_reg <= page2_next;
      aby_reg   <= aby_next;
      done_reg  <= done_next;
      cyc_reg   <= cyc_next;
      rw_reg    <= 1'b1;
    end
  end

  assign bus_addr           = addr_reg;
  assign bus_rw             = rw_reg;
  assign pc                 = pc_reg;
  assign first_acc          = a_reg;
  assign second_accumulator = b_reg;
  assign first_index_reg    = x_reg;
  assign second_index_reg   = y_reg;
  assign ccr                = ccr_reg;
  assign instr_done         = done_reg;

  // Checks. Helper bits feed the boolean flag forms.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_sync);

  logic x3, m3, r3, x7, m7, r7;
  assign x3 = alu_bus.x[3];
  assign m3 = alu_bus.m[3];
  assign r3 = alu_bus.r[3];
  assign x7 = alu_bus.x[7];
  assign m7 = alu_bus.m[7];
  assign r7 = alu_bus.r[7];

  sequence s_aby_tail;
    (st_reg == cai_pkg::ST_ABY3) ##1
    (st_reg == cai_pkg::ST_IDLE && bus_addr == cai_pkg::IDLE_ADDR) ##1
    (st_reg == cai_pkg::ST_FETCH && instr_done);
  endsequence

  // A preload anywhere in the walk restarts the core, so it aborts the check.
  chk_aby_walk: assert property (
    @(posedge clk) disable iff (!rst_n_sync || load_strobe)
    (st_reg == cai_pkg::ST_PAGE2 && bus_data_in == cai_pkg::OP_ADD_B_Y)
    |=> s_aby_tail)
    else $error("add-b-to-y bus walk wrong");

  chk_aby_sum: assert property (
    (st_reg == cai_pkg::ST_IDLE && aby_reg && !load_strobe) |=>
    (y_reg == $past(y_reg) + {cai_pkg::ZERO_BYTE, $past(b_reg)}) &&
    (b_reg == $past(b_reg)) && (ccr_reg == $past(ccr_reg)))
    else $error("add-b-to-y result or side effects wrong");

  chk_acc_sum: assert property (
    (exec_now && !load_strobe) |=>
    (($past(dec_reg.to_b) ? b_reg : a_reg) ==
     $past(alu_bus.x) + $past(alu_bus.m) +
     {7'h00, $past(dec_reg.with_c) & $past(ccr_reg[cai_pkg::CC_C])}))
    else $error("accumulator sum wrong");

  chk_half_carry: assert property (
    (exec_now && !load_strobe) |=>
    ccr_reg[cai_pkg::CC_H] == $past(x3 & m3 | m3 & ~r3 | ~r3 & x3))
    else $error("half carry wrong");

  chk_neg_zero: assert property (
    (exec_now && !load_strobe) |=>
    (ccr_reg[cai_pkg::CC_N] == $past(alu_bus.r[7])) &&
    (ccr_reg[cai_pkg::CC_Z] == ($past(alu_bus.r) == cai_pkg::ZERO_BYTE)))
    else $error("negative or zero flag wrong");

  chk_overflow_flag: assert property (
    (exec_now && !load_strobe) |=>
    ccr_reg[cai_pkg::CC_V] == $past(x7 & m7 & ~r7 | ~x7 & ~m7 & r7))
    else $error("overflow flag wrong");

  chk_carry_out: assert property (
    (exec_now && !load_strobe) |=>
    ccr_reg[cai_pkg::CC_C] == $past(x7 & m7 | m7 & ~r7 | ~r7 & x7))
    else $error("carry flag wrong");

  chk_mask_bits: assert property (
    !load_strobe |=>
    ccr_reg[cai_pkg::CC_S] == $past(ccr_reg[cai_pkg::CC_S]) &&
    ccr_reg[cai_pkg::CC_X] == $past(ccr_reg[cai_pkg::CC_X]) &&
    ccr_reg[cai_pkg::CC_I] == $past(ccr_reg[cai_pkg::CC_I]))
    else $error("mask flags changed");

  chk_page_zero: assert property (
    (st_reg == cai_pkg::ST_OPREAD && dec_reg.mode == cai_pkg::MODE_PAGE0)
    |-> bus_addr[15:8] == cai_pkg::PAGE_ZERO_HI)
    else $error("page-zero high byte not zero");

  chk_index_addr: assert property (
    (st_reg == cai_pkg::ST_IDLE && !aby_reg && !load_strobe) |->
    bus_addr == cai_pkg::IDLE_ADDR ##1
    (st_reg == cai_pkg::ST_OPREAD && bus_addr ==
     (page2_reg ? y_reg : x_reg) + {cai_pkg::ZERO_BYTE, hi_reg}))
    else $error("indexed address wrong");

  chk_cycle_count: assert property (
    exec_now |-> cyc_reg == cyc_expect(dec_reg.mode, page2_reg))
    else $error("instruction cycle count wrong");

  chk_read_only: assert property (
    bus_rw == 1'b1)
    else $error("bus left read direction");

endmodule // cai_core

// ---- hdl/cai_pkg.sv ----
/*
  Constants, types and the rule summary for the add-instruction core subset.
  Assumes a single clock and a read-only memory bus with data valid in the
  same cycle as its address.
*/
// Summary of operation
// - Index Y gains zero-extended B with carry; the code adds B alone, no carry
// - B and all flags untouched by that add
// - Opcode 18 3A, four reads, last at FFFF
// - Add-with-carry sums operand, carry, accumulator
// - Half-carry from bit 3 formula
// - N copies bit 7; Z when zero
// - Overflow on same-sign operands, flipped result
// - Carry from bit 7 formula
// - Literal 2, page-zero 3, full 4 reads
// - Plain add ignores carry, same flags
// - Half-carry kept for later decimal adjust
// - Page-zero high address byte is zero
// - Index offset is unsigned 0 to 255
package cai_pkg;

  // Prefix, prefixed and single-byte opcodes.
  localparam logic [7:0] OP_PREFIX2 = 8'h18;
  localparam logic [7:0] OP_ADD_B_Y = 8'h3A;
  localparam logic [7:0] OP_ADD_CARRY_TO_FIRST_ACC_LIT = 8'h89;
  localparam logic [7:0] OP_ADD_CARRY_TO_FIRST_ACC_PZ  = 8'h99;
  localparam logic [7:0] OP_ADD_CARRY_TO_FIRST_ACC_FUL = 8'hB9;
  localparam logic [7:0] OP_ADD_CARRY_TO_FIRST_ACC_IDX = 8'hA9;
  localparam logic [7:0] OP_ADD_CARRY_TO_SECOND_ACC_LIT = 8'hC9;
  localparam logic [7:0] OP_ADD_CARRY_TO_SECOND_ACC_PZ  = 8'hD9;
  localparam logic [7:0] OP_ADD_CARRY_TO_SECOND_ACC_FUL = 8'hF9;
  localparam logic [7:0] OP_ADD_CARRY_TO_SECOND_ACC_IDX = 8'hE9;
  localparam logic [7:0] OP_PLAIN_ADD_FIRST_ACC_LIT = 8'h8B;
  localparam logic [7:0] OP_PLAIN_ADD_FIRST_ACC_PZ  = 8'h9B;
  localparam logic [7:0] OP_PLAIN_ADD_FIRST_ACC_FUL = 8'hBB;
  localparam logic [7:0] OP_PLAIN_ADD_FIRST_ACC_IDX = 8'hAB;
  localparam logic [7:0] OP_PLAIN_ADD_SECOND_ACC_LIT = 8'hCB;
  localparam logic [7:0] OP_PLAIN_ADD_SECOND_ACC_PZ  = 8'hDB;
  localparam logic [7:0] OP_PLAIN_ADD_SECOND_ACC_FUL = 8'hFB;
  localparam logic [7:0] OP_PLAIN_ADD_SECOND_ACC_IDX = 8'hEB;

  // Bus addresses and fills.
  localparam logic [15:0] IDLE_ADDR    = 16'hFFFF;
  localparam logic [7:0]  PAGE_ZERO_HI = 8'h00;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  localparam logic [15:0] ADDR_STEP    = 16'h0001;

  // Condition code bit positions.
  localparam int CC_S = 7;
  localparam int CC_X = 6;
  localparam int CC_H = 5;
  localparam int CC_I = 4;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;

  // Reset values.
  localparam logic [15:0] RESET_PC  = 16'h0000;
  localparam logic [7:0]  RESET_CCR = 8'h00;
  localparam logic [7:0]  RESET_ACC = 8'h00;
  localparam logic [15:0] RESET_IDX = 16'h0000;

  // Bus cycles per addressing form.
  localparam logic [2:0] CYC_LIT   = 3'h2;
  localparam logic [2:0] CYC_PZ    = 3'h3;
  localparam logic [2:0] CYC_FULL  = 3'h4;
  localparam logic [2:0] CYC_IDX_X = 3'h4;
  localparam logic [2:0] CYC_IDX_Y = 3'h5;
  localparam logic [2:0] CYC_FIRST = 3'h1;

  typedef enum logic [2:0] {
    MODE_NONE, MODE_LIT, MODE_PAGE0, MODE_FULL, MODE_IDX
  } cai_mode_t;

  typedef struct packed {
    logic      hit;
    logic      to_b;
    logic      with_c;
    cai_mode_t mode;
  } cai_dec_t;

  typedef enum logic [2:0] {
    ST_FETCH, ST_PAGE2, ST_OPND, ST_EXTLO, ST_ABY3, ST_IDLE, ST_OPREAD
  } cai_state_t;

endpackage

// ---- hdl/cai_alu_if.sv ----
/*
  Carrier between the core sequencer and its 8-bit adder.
  Assumes both ends sit in the same clock domain; all signals are
  combinational.
*/
`timescale 1ns/1ps
interface cai_alu_if;
  logic [7:0] x;
  logic [7:0] m;
  logic       cin;
  logic       with_c;
  logic [7:0] r;
  logic       h;
  logic       n;
  logic       z;
  logic       v;
  logic       c;

  modport core (output x, m, cin, with_c, input r, h, n, z, v, c);
  modport alu  (input x, m, cin, with_c, output r, h, n, z, v, c);
endinterface // cai_alu_if

// ---- hdl/cai_alu.sv ----
/*
  Eight-bit adder with condition flag outputs.
  Assumes the caller picks the accumulator; the carry in is gated by with_c here.
*/
`timescale 1ns/1ps
module cai_alu (
  cai_alu_if.alu a
);

  logic       cin_eff;
  logic [8:0] sum;
  logic [4:0] low_sum;

  // Carry and half-carry come from real carries out of the adder rather than formulas,
  // so the sequencer checks can compare against the boolean forms.
  always_comb begin
    cin_eff = a.with_c & a.cin;
    sum     = {1'b0, a.x} + {1'b0, a.m} + {8'h00, cin_eff};
    low_sum = {1'b0, a.x[3:0]} + {1'b0, a.m[3:0]} + {4'h0, cin_eff};
    a.r = sum[7:0];
    a.c = sum[8];
    a.h = low_sum[4];
    a.n = sum[7];
    a.z = (sum[7:0] == cai_pkg::ZERO_BYTE);
    a.v = (a.x[7] == a.m[7]) && (sum[7] != a.x[7]);
  end

endmodule // cai_alu

// ---- verif/cai_mem_model.sv ----
/*
  Program and data memory for the add-instruction core.
  Assumes the bench writes mem directly and that reads need no wait state.
*/
`timescale 1ns/1ps
module cai_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rw,
  output logic      [7:0]  bus_data_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] idle_reg = 8'hA5;

  // Unwritten bytes hold an opcode the core skips.
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h01;
  end

  // The idle pattern moves every cycle so stale data never looks valid.
  always @(posedge clk) begin
    idle_reg <= idle_reg + 8'h3B;
  end

  // Idle or non-read cycles get junk rather than a stored byte.
  assign bus_data_in = (!bus_rw || bus_addr == 16'hFFFF) ? idle_reg
                                                        : mem[bus_addr];
endmodule // cai_mem_model

// ---- verif/cpu_add_instruction_subset_tb_top.sv ----
/*
  Self-checking bench for the add-instruction core.
  Assumes the memory model answers in the same cycle as the address.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin cmp_count++; if ((got) !== (ex)) begin n_fail++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module cpu_add_instruction_subset_tb_top;
  typedef struct packed {
    logic [2:0] mode;
    logic [7:0] op;
    logic [7:0] acc;
    logic [7:0] m;
    logic       cin;
  } cai_row_t;
  localparam logic [15:0] OP = 16'h0100;
  localparam logic [15:0] EA [0:5] = '{16'h0000, 16'h0040, 16'h1234,
                                       16'h21E0, 16'h3100, 16'h0080};
  localparam int          CYC [0:5] = '{2, 3, 4, 4, 5, 4};
  localparam int          LEN [0:5] = '{2, 2, 3, 2, 3, 2};
  logic        clk, reset_n, load_strobe, bus_rw, instr_done;
  logic [7:0]  bus_data_in, load_a, load_b, load_ccr;
  logic [7:0]  first_acc, second_accumulator, ccr;
  logic [15:0] load_pc, load_x, load_y, bus_addr, pc;
  logic [15:0] first_index_reg, second_index_reg;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          n;
  // Modes: 0 literal, 1 page zero, 2 full, 3 first index, 4 second index.
  cai_row_t rows [0:15] = '{
    '{3'h0, 8'h89, 8'h7F, 8'h00, 1'h1}, '{3'h1, 8'h99, 8'hFF, 8'h00, 1'h1},
    '{3'h2, 8'hB9, 8'h80, 8'h80, 1'h0}, '{3'h3, 8'hA9, 8'h12, 8'h34, 1'h1},
    '{3'h4, 8'hA9, 8'h08, 8'h08, 1'h0}, '{3'h0, 8'hC9, 8'h40, 8'h3F, 1'h1},
    '{3'h1, 8'hD9, 8'h0F, 8'hF0, 1'h1}, '{3'h2, 8'hF9, 8'hC0, 8'h40, 1'h0},
    '{3'h3, 8'hE9, 8'h88, 8'h88, 1'h1}, '{3'h4, 8'hE9, 8'h01, 8'hFE, 1'h0},
    '{3'h0, 8'h8B, 8'h01, 8'h01, 1'h1}, '{3'h1, 8'h9B, 8'h7F, 8'h01, 1'h1},
    '{3'h2, 8'hFB, 8'hFF, 8'hFF, 1'h1}, '{3'h3, 8'hAB, 8'h08, 8'h08, 1'h0},
    '{3'h4, 8'hEB, 8'h80, 8'hFF, 1'h1}, '{3'h5, 8'h3A, 8'hFF, 8'h00, 1'h1}};

  cai_core dut_u (
    .clk                     (clk),
    .reset_n                 (reset_n),
    .bus_data_in             (bus_data_in),
    .load_strobe             (load_strobe),
    .load_pc                 (load_pc),
    .load_first_acc          (load_a),
    .load_second_accumulator (load_b),
    .load_first_index_reg    (load_x),
    .load_second_index_reg   (load_y),
    .load_ccr                (load_ccr),
    .bus_addr                (bus_addr),
    .bus_rw                  (bus_rw),
    .pc                      (pc),
    .first_acc               (first_acc),
    .second_accumulator      (second_accumulator),
    .first_index_reg         (first_index_reg),
    .second_index_reg        (second_index_reg),
    .ccr                     (ccr),
    .instr_done              (instr_done)
  );

  cai_mem_model mem_u (
    .clk         (clk),
    .bus_addr    (bus_addr),
    .bus_rw      (bus_rw),
    .bus_data_in (bus_data_in)
  );

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // A hang costs far more than the whole run should take.
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 2000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Preload ends one cycle after the strobe edge, in the first fetch cycle.
  task automatic preload(input logic [15:0] p, input logic [7:0] a, b,
                         input logic [15:0] x, y, input logic [7:0] c);
    @(posedge clk);
    #1;
    load_pc = p;
    load_a = a;
    load_b = b;
    load_x = x;
    load_y = y;
    load_ccr = c;
    load_strobe = 1'b1;
    @(posedge clk);
    #1;
    load_strobe = 1'b0;
  endtask

  // Counts cycles to the done pulse, bounded so a silent core cannot hang.
  task automatic wait_done(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (instr_done !== 1'b1 && k < 10);
  endtask

  task automatic chk_zero();
    `CHK("bus_addr", 16'h0000, bus_addr);
    `CHK("pc", 16'h0000, pc);
    `CHK("accs", 16'h0000, {first_acc, second_accumulator});
    `CHK("index", 32'h0000_0000, {first_index_reg, second_index_reg});
    `CHK("ccr", 8'h00, ccr);
    `CHK("done_rw", 2'h1, {instr_done, bus_rw});
  endtask

  // One table row: build the program, walk the bus, then check registers.
  task automatic run_row(input cai_row_t r, input logic sxi);
    logic [15:0] ex [0:5];
    logic [7:0]  a0, b0, c0, x, s;
    logic [8:0]  s9;
    logic        tb, h, v, c;
    tb = r.op[6] | (r.mode == 3'h5);
    a0 = tb ? 8'h5A : r.acc;
    b0 = tb ? r.acc : 8'hA5;
    c0 = {sxi, sxi, 1'h0, sxi, 3'h0, r.cin};
    for (int i = 0; i < 5; i++) mem_u.mem[OP + i] = 8'h01;
    mem_u.mem[OP] = r.op;
    mem_u.mem[OP + 16'h2] = 8'h34;
    case (r.mode)
      3'h0: mem_u.mem[OP + 16'h1] = r.m;
      3'h1: mem_u.mem[OP + 16'h1] = 8'h40;
      3'h2: mem_u.mem[OP + 16'h1] = 8'h12;
      3'h3: mem_u.mem[OP + 16'h1] = 8'hF0;
      default: begin
        mem_u.mem[OP] = 8'h18;
        mem_u.mem[OP + 16'h1] = r.op;
        mem_u.mem[OP + 16'h2] = 8'hFF;
      end
    endcase
    if (r.mode != 3'h0 && r.mode != 3'h5) mem_u.mem[EA[r.mode]] = r.m;
    ex[0] = OP;
    ex[1] = OP + 16'h1;
    ex[2] = (r.mode == 3'h3) ? 16'hFFFF : OP + 16'h2;
    ex[3] = 16'hFFFF;
    if (r.mode != 3'h0 && r.mode != 3'h5) ex[CYC[r.mode]-1] = EA[r.mode];
    x = tb ? b0 : a0;
    s9 = {1'h0, x} + {1'h0, r.m} + {8'h00, r.cin & ~r.op[1]};
    s = s9[7:0];
    h = x[3] & r.m[3] | r.m[3] & ~s[3] | ~s[3] & x[3];
    c = x[7] & r.m[7] | r.m[7] & ~s[7] | ~s[7] & x[7];
    v = x[7] & r.m[7] & ~s[7] | ~x[7] & ~r.m[7] & s[7];
    preload(OP, a0, b0, 16'h20F0, 16'h3001, c0);
    n = 0;
    while (instr_done !== 1'b1 && n < 8) begin
      if (n < CYC[r.mode]) `CHK("bus_addr", ex[n], bus_addr);
      `CHK("bus_rw", 1'b1, bus_rw);
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("cycles", CYC[r.mode], n);
    `CHK("next_fetch", OP + LEN[r.mode], bus_addr);
    `CHK("pc", OP + LEN[r.mode], pc);
    `CHK("first_index", 16'h20F0, first_index_reg);
    if (r.mode == 3'h5) begin
      `CHK("second_index", 16'h3001 + {8'h00, b0}, second_index_reg);
      `CHK("second_acc", b0, second_accumulator);
      `CHK("ccr", c0, ccr);
    end else begin
      `CHK("acc", s, tb ? second_accumulator : first_acc);
      `CHK("other", tb ? a0 : b0, tb ? first_acc : second_accumulator);
      `CHK("ccr", {c0[7:6], h, c0[4], s[7], s == 8'h00, v, c}, ccr);
    end
  endtask

  // Main sequence: reset, table rows, then the awkward cases.
  initial begin
    reset_n = 1'b0;
    load_strobe = 1'b0;
    {load_pc, load_a, load_b, load_x, load_y, load_ccr} = '0;
    repeat (16) @(posedge clk);
    #1;
    chk_zero();
    reset_n = 1'b1;
    $display("test reset done, mismatches %0d", n_fail);
    repeat (2) @(posedge clk);
    foreach (rows[i]) begin
      run_row(rows[i], i[0]);
      $display("test row %0d done, mismatches %0d", i, n_fail);
    end
    // Skipped opcode, then two back-to-back adds chaining the carry.
    mem_u.mem[16'h0201] = 8'h89;
    mem_u.mem[16'h0202] = 8'hFF;
    mem_u.mem[16'h0203] = 8'h89;
    mem_u.mem[16'h0204] = 8'h00;
    preload(16'h0200, 8'h01, 8'h00, 16'h0000, 16'h0000, 8'h00);
    wait_done(n);
    `CHK("cycles", 3, n);
    `CHK("acc", 8'h00, first_acc);
    `CHK("ccr", 8'h25, ccr);
    wait_done(n);
    `CHK("cycles", 2, n);
    `CHK("acc", 8'h01, first_acc);
    `CHK("ccr", 8'h00, ccr);
    $display("test back_to_back done, mismatches %0d", n_fail);
    // Reset inside an add-b-to-y, then a clean restart and a full add.
    preload(16'h0100, 8'h11, 8'h22, 16'h0003, 16'h0004, 8'hFF);
    @(posedge clk);
    #1;
    reset_n = 1'b0;
    #1;
    chk_zero();
    @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_zero();
    run_row(rows[2], 1'b1);
    $display("test mid_reset done, mismatches %0d", n_fail);
    conclude();
  end
endmodule // cpu_add_instruction_subset_tb_top
